// ---- design/cdgs_pkg.sv ----
// shared constants of the clock divider / go / status block
// assumes a single 100 MHz core clock and a plain register port
package cdgs_pkg;

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;  // byte address width
    localparam int DATA_W = 32; // register data width
    localparam logic [7:0] ADR_DIV4 = 8'h00; // fourth_clock_divider
    localparam logic [7:0] ADR_CMD = 8'h04;  // go_command
    localparam logic [7:0] ADR_STAT = 8'h08; // controller_status
    localparam logic [7:0] ADR_RUN = 8'h0c;  // clock_running_status
    localparam logic [7:0] ADR_ALN = 8'h10;  // alignment_select
    localparam logic [7:0] ADR_CHG = 8'h14;  // ratio_changed_flags
    localparam logic [7:0] ADR_IST = 8'h18;  // interrupt status, w1c
    localparam logic [7:0] ADR_IMSK = 8'h1c; // interrupt mask

    // ---------------------------------------------------------------
    // field layout
    // ---------------------------------------------------------------
    localparam int DIV_EN_BIT = 15; // fourth_divider_enable
    localparam int RATIO_W = 3;     // ratio field, bits 2..0
    localparam int GO_BIT = 0;      // go_command_bit
    localparam int GO_IN_PROGRESS_BIT = 0;  // go_in_progress
    localparam int STABLE_BIT = 2;  // oscillator stable
    localparam int NCLK = 6;        // derived clocks one to six
    localparam int CLK4_IDX = 3;    // bit of the fourth clock
    localparam int IRQ_GO_DONE = 0; // go finished event
    localparam int IRQ_STABLE = 1;  // oscillator became stable
    localparam int IRQ_W = 2;       // number of events

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic DIV_EN_RST = 1'b1;
    localparam logic [2:0] RATIO_RST_PRI = 3'h3; // divide by four
    localparam logic [2:0] RATIO_RST_SEC = 3'h0;
    localparam logic [5:0] ALL_CLK = 6'h3f;
    localparam logic [5:0] NO_CLK = 6'h00;
    localparam logic [1:0] NO_IRQ = 2'h0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10; // core clock period
    localparam int GO_SYNC_NS = 80;    // longest wait for a phase edge
    localparam int GO_SYNC_CYC =
        (GO_SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_W = 4; // width of the sync wait counter
    localparam logic [3:0] SYNC_LAST = 4'(GO_SYNC_CYC - 1);

    // ---------------------------------------------------------------
    // go sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        GO_IDLE = 2'b00, // nothing in progress
        GO_SYNC = 2'b01, // waiting for a phase boundary
        GO_LOAD = 2'b10  // loading ratios and realigning
    } cdgs_go_state_t;

endpackage

// ---- design/cdgs_div.sv ----
// one programmable integer divider producing a clock-enable tick
// assumes ratio is steady except at a restart or while disabled
`timescale 1ns/1ns

module cdgs_div #(
    parameter int W = 3 // ratio width
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,          // divider enabled
    input wire logic [W-1:0] ratio_i, // divide by ratio + 1
    input wire logic restart_i,     // restart the phase at zero
    output logic tick_o,            // one cycle every ratio + 1
    output logic wrap_o             // count sits at its last value
);

    logic [W-1:0] cnt_q; // phase counter
    logic [W-1:0] cnt_d;
    logic tick_q;        // registered tick
    logic tick_d;

    // ---------------------------------------------------------------
    // next count and tick
    // ---------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (!en_i || restart_i) begin
            cnt_d = '0; // held or realigned to phase zero
        end else if (cnt_q >= ratio_i) begin
            cnt_d = '0; // end of one divided period
        end else begin
            cnt_d = cnt_q + W'(1);
        end
        // disabled divider passes nothing
        tick_d = en_i && (cnt_d == '0);
    end

    // registers only
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
    assign wrap_o = en_i && (cnt_q >= ratio_i);

endmodule

// ---- design/cdgs_top.sv ----
// clock divider, go command and status block of a clock controller
// assumes one 100 MHz clock, a plain register port with read data
// one cycle after the read strobe, and external dividers one to six
`timescale 1ns/1ns

module cdgs_top #(
    parameter bit PRIMARY = 1'b1,    // primary controller instance
    parameter int OSC_CYCLES = 0     // stabilisation count after reset
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,   // register byte address
    input wire logic [31:0] wdata_i, // register write data
    input wire logic wr_i,           // write strobe
    input wire logic rd_i,           // read strobe
    output logic [31:0] rdata_o,     // read data, cycle after rd_i
    input wire logic [5:0] ratio_write_i, // other dividers rewritten
    input wire logic [5:0] clk_on_i,      // external clocks running
    output logic fourth_system_clock_o,   // divided clock tick
    output logic [5:0] ratio_load_o,      // load pulse per clock
    output logic [5:0] align_restart_o,   // realign pulse per clock
    output logic go_in_progress_o,        // go sequence busy
    output logic irq_o                    // level interrupt
);

    // ---------------------------------------------------------------
    // reset constants of this instance
    // ---------------------------------------------------------------
    localparam logic [2:0] RATIO_RST =
        PRIMARY ? cdgs_pkg::RATIO_RST_PRI : cdgs_pkg::RATIO_RST_SEC;
    localparam logic DIV_RST = PRIMARY ? cdgs_pkg::DIV_EN_RST : 1'b0;
    localparam logic [5:0] ON_RST =
        PRIMARY ? cdgs_pkg::ALL_CLK : cdgs_pkg::NO_CLK;
    localparam logic STABLE_RST = (OSC_CYCLES == 0);
    localparam int OSC_W = (OSC_CYCLES > 1) ? $clog2(OSC_CYCLES + 1) : 1;
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_CYCLES);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic div_en_q, div_en_d;           // fourth_divider_enable
    logic [2:0] prog_ratio_q, prog_ratio_d; // ratio as written
    logic [2:0] act_ratio_q, act_ratio_d;   // ratio in use
    logic go_bit_q, go_bit_d;           // stored go_command_bit
    logic [5:0] aln_q, aln_d;           // alignment_select
    logic [5:0] chg_q, chg_d;           // ratio_changed_flags
    logic [5:0] on_q, on_d;             // clock running status
    logic [1:0] ist_q, ist_d;           // sticky interrupt status
    logic [1:0] imsk_q, imsk_d;         // interrupt mask
    logic irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;
    cdgs_pkg::cdgs_go_state_t st_q, st_d; // go sequencer
    logic [3:0] sync_q, sync_d;         // wait count in sync
    logic busy_q, busy_d;
    logic [5:0] load_q, load_d;
    logic [5:0] algn_q, algn_d;
    logic stable_q, stable_d;           // oscillator stable
    logic [OSC_W-1:0] osc_q, osc_d;     // stabilisation counter

    // decoded accesses
    logic wr_div, wr_cmd, wr_aln, wr_ist, wr_imsk;
    logic go_start;   // accepted go request
    logic div_restart; // realign the fourth divider
    logic div_wrap;    // fourth divider at a phase boundary
    logic div_tick;
    logic [2:0] wr_ratio; // ratio field of the write data

    // ---------------------------------------------------------------
    // write decode
    // ---------------------------------------------------------------
    always_comb begin
        wr_div = wr_i && (addr_i == cdgs_pkg::ADR_DIV4) && PRIMARY;
        wr_cmd = wr_i && (addr_i == cdgs_pkg::ADR_CMD);
        wr_aln = wr_i && (addr_i == cdgs_pkg::ADR_ALN);
        wr_ist = wr_i && (addr_i == cdgs_pkg::ADR_IST);
        wr_imsk = wr_i && (addr_i == cdgs_pkg::ADR_IMSK);
        wr_ratio = wdata_i[cdgs_pkg::RATIO_W-1:0];
        // a one starts go; a zero never does; ignored while busy
        go_start = wr_cmd && wdata_i[cdgs_pkg::GO_BIT]
            && (st_q == cdgs_pkg::GO_IDLE);
    end

    // ---------------------------------------------------------------
    // divider and command registers, next values
    // ---------------------------------------------------------------
    always_comb begin
        div_en_d = div_en_q;
        prog_ratio_d = prog_ratio_q;
        act_ratio_d = act_ratio_q;
        go_bit_d = go_bit_q;
        aln_d = aln_q;
        if (wr_div) begin
            div_en_d = wdata_i[cdgs_pkg::DIV_EN_BIT];
            prog_ratio_d = wr_ratio;
        end
        // stored go bit follows every write to the command register
        if (wr_cmd) begin
            go_bit_d = wdata_i[cdgs_pkg::GO_BIT];
        end
        if (wr_aln) begin
            aln_d = wdata_i[cdgs_pkg::NCLK-1:0];
        end
        // new ratio takes effect only when go loads it
        if (st_q == cdgs_pkg::GO_LOAD && chg_q[cdgs_pkg::CLK4_IDX]) begin
            act_ratio_d = prog_ratio_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_en_q <= DIV_RST;
            prog_ratio_q <= RATIO_RST;
            act_ratio_q <= RATIO_RST;
            go_bit_q <= 1'b0;
            aln_q <= ON_RST;
        end else begin
            div_en_q <= div_en_d;
            prog_ratio_q <= prog_ratio_d;
            act_ratio_q <= act_ratio_d;
            go_bit_q <= go_bit_d;
            aln_q <= aln_d;
        end
    end

    // ---------------------------------------------------------------
    // ratio changed flags
    // ---------------------------------------------------------------
    always_comb begin
        chg_d = chg_q;
        // a load clears all the flags, consumed or not
        if (st_q == cdgs_pkg::GO_LOAD) begin
            chg_d = cdgs_pkg::NO_CLK;
        end
        // a rewrite in the same cycle wins over that clear
        chg_d = chg_d | ratio_write_i;
        if (wr_div && (wr_ratio != prog_ratio_q)) begin
            chg_d[cdgs_pkg::CLK4_IDX] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chg_q <= cdgs_pkg::NO_CLK;
        end else begin
            chg_q <= chg_d;
        end
    end

    // ---------------------------------------------------------------
    // go sequencer
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        sync_d = sync_q;
        load_d = cdgs_pkg::NO_CLK;
        algn_d = cdgs_pkg::NO_CLK;
        case (st_q)
            cdgs_pkg::GO_IDLE: begin
                sync_d = '0;
                if (go_start) begin
                    st_d = cdgs_pkg::GO_SYNC;
                end
            end
            cdgs_pkg::GO_SYNC: begin
                // wait for the fourth clock's phase edge, bounded
                if (div_wrap || !div_en_q || sync_q == cdgs_pkg::SYNC_LAST)
                begin
                    st_d = cdgs_pkg::GO_LOAD;
                    load_d = chg_q;
                    algn_d = aln_q & on_q;
                end else begin
                    sync_d = sync_q + 4'h1;
                end
            end
            cdgs_pkg::GO_LOAD: begin
                st_d = cdgs_pkg::GO_IDLE;
            end
            default: begin
                st_d = cdgs_pkg::GO_IDLE;
            end
        endcase
        busy_d = (st_d != cdgs_pkg::GO_IDLE);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= cdgs_pkg::GO_IDLE;
            sync_q <= '0;
            busy_q <= 1'b0;
            load_q <= cdgs_pkg::NO_CLK;
            algn_q <= cdgs_pkg::NO_CLK;
        end else begin
            st_q <= st_d;
            sync_q <= sync_d;
            busy_q <= busy_d;
            load_q <= load_d;
            algn_q <= algn_d;
        end
    end

    // fourth divider restarts on the same load edge as the others
    assign div_restart = (st_q == cdgs_pkg::GO_LOAD)
        && aln_q[cdgs_pkg::CLK4_IDX];

    // ---------------------------------------------------------------
    // fourth clock divider
    // ---------------------------------------------------------------
    cdgs_div #(
        .W(cdgs_pkg::RATIO_W)
    ) u_div4 (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .en_i(div_en_q),
        .ratio_i(act_ratio_q),
        .restart_i(div_restart),
        .tick_o(div_tick),
        .wrap_o(div_wrap)
    );

    // ---------------------------------------------------------------
    // oscillator stable and clock running status
    // ---------------------------------------------------------------
    always_comb begin
        osc_d = osc_q;
        stable_d = stable_q;
        if (osc_q != OSC_LAST) begin
            osc_d = osc_q + OSC_W'(1);
        end
        if (osc_d == OSC_LAST) begin
            stable_d = 1'b1;
        end
        on_d = clk_on_i;
        on_d[cdgs_pkg::CLK4_IDX] = div_en_q;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_q <= '0;
            stable_q <= STABLE_RST;
            on_q <= ON_RST;
        end else begin
            osc_q <= osc_d;
            stable_q <= stable_d;
            on_q <= on_d;
        end
    end

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    always_comb begin
        ist_d = ist_q;
        imsk_d = imsk_q;
        if (wr_imsk) begin
            imsk_d = wdata_i[cdgs_pkg::IRQ_W-1:0];
        end
        if (wr_ist) begin
            ist_d = ist_q & ~wdata_i[cdgs_pkg::IRQ_W-1:0];
        end
        // events set after the clear, so they win
        if (st_q == cdgs_pkg::GO_LOAD) begin
            ist_d[cdgs_pkg::IRQ_GO_DONE] = 1'b1;
        end
        if (stable_d && !stable_q) begin
            ist_d[cdgs_pkg::IRQ_STABLE] = 1'b1;
        end
        irq_d = |(ist_d & imsk_d);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ist_q <= cdgs_pkg::NO_IRQ;
            imsk_q <= cdgs_pkg::NO_IRQ;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            irq_q <= irq_d;
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always_comb begin
        rdata_d = '0; // unmapped and idle cycles read zero
        if (rd_i) begin
            case (addr_i)
                cdgs_pkg::ADR_DIV4: begin
                    if (PRIMARY) begin
                        rdata_d[cdgs_pkg::DIV_EN_BIT] = div_en_q;
                        rdata_d[cdgs_pkg::RATIO_W-1:0] = prog_ratio_q;
                    end
                end
                cdgs_pkg::ADR_CMD: begin
                    rdata_d[cdgs_pkg::GO_BIT] = go_bit_q;
                end
                cdgs_pkg::ADR_STAT: begin
                    rdata_d[cdgs_pkg::GO_IN_PROGRESS_BIT] =
                        (st_q != cdgs_pkg::GO_IDLE);
                    rdata_d[cdgs_pkg::STABLE_BIT] = stable_q;
                end
                cdgs_pkg::ADR_RUN: begin
                    rdata_d[cdgs_pkg::NCLK-1:0] = on_q;
                end
                cdgs_pkg::ADR_ALN: begin
                    rdata_d[cdgs_pkg::NCLK-1:0] = aln_q;
                end
                cdgs_pkg::ADR_CHG: begin
                    rdata_d[cdgs_pkg::NCLK-1:0] = chg_q;
                end
                cdgs_pkg::ADR_IST: begin
                    rdata_d[cdgs_pkg::IRQ_W-1:0] = ist_q;
                end
                cdgs_pkg::ADR_IMSK: begin
                    rdata_d[cdgs_pkg::IRQ_W-1:0] = imsk_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flops
    // ---------------------------------------------------------------
    assign rdata_o = rdata_q;
    assign fourth_system_clock_o = div_tick;
    assign ratio_load_o = load_q;
    assign align_restart_o = algn_q;
    assign go_in_progress_o = busy_q;
    assign irq_o = irq_q;

endmodule

// ---- sim/cdgs_props.sv ----
// checker for the clock divider / go / status block
// assumes only the top ports; bound to every instance of the top
`timescale 1ns/1ns
module cdgs_props #(
    parameter bit PRIMARY = 1'b1,
    parameter int OSC_CYCLES = 0
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [5:0] ratio_write_i,
    input wire logic [5:0] clk_on_i,
    input wire logic fourth_system_clock_o,
    input wire logic [5:0] ratio_load_o,
    input wire logic [5:0] align_restart_o,
    input wire logic go_in_progress_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic en_q; // shadow of the divider enable
    logic en_d;
    logic go_wr; // one written to the go bit
    logic go_zero; // zero written to the go bit
    logic st_rd; // status read
    assign go_wr = wr_i && addr_i == cdgs_pkg::ADR_CMD && wdata_i[0];
    assign go_zero = wr_i && addr_i == cdgs_pkg::ADR_CMD && !wdata_i[0];
    assign st_rd = rd_i && addr_i == cdgs_pkg::ADR_STAT;
    // next enable from divider writes, primary only
    always_comb begin
        en_d = en_q;
        if (PRIMARY && wr_i && addr_i == cdgs_pkg::ADR_DIV4) begin
            en_d = wdata_i[cdgs_pkg::DIV_EN_BIT];
        end
    end
    // register the shadow
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_q <= PRIMARY;
        end else begin
            en_q <= en_d;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside read");
    a_go_next: assert property (go_wr && !go_in_progress_o |=> go_in_progress_o)
        else $error("go status not set after go write");
    a_go_ends: assert property ($rose(go_in_progress_o) |-> ##[1:10] !go_in_progress_o)
        else $error("go status stuck");
    a_zero_inert: assert property (go_zero && !go_in_progress_o |=> !go_in_progress_o)
        else $error("zero write started go");
    a_load_busy: assert property ((|ratio_load_o) || (|align_restart_o) |-> go_in_progress_o)
        else $error("load pulse outside go");
    a_load_pulse: assert property ((|ratio_load_o) |=> ratio_load_o == 6'h00)
        else $error("load pulse longer than one cycle");
    a_align_done: assert property ((|align_restart_o) |=> align_restart_o == 6'h00 && !go_in_progress_o)
        else $error("align pulse not followed by idle");
    a_tick_off: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) |-> !fourth_system_clock_o)
        else $error("tick while divider disabled");
    a_stat_go: assert property (st_rd |=> rdata_o[0] == $past(go_in_progress_o) && rdata_o[31:3] == 29'h0 && !rdata_o[1])
        else $error("status read wrong");
    a_stable_read: assert property (st_rd && OSC_CYCLES == 0 |=> rdata_o[2])
        else $error("stable bit low");
    // running bit follows the enable one cycle late, then read latency
    a_run_enable: assert property (
        rd_i && addr_i == cdgs_pkg::ADR_RUN |=> rdata_o[3] == $past(en_q, 2))
        else $error("fourth running bit wrong");
    c_go: cover property ($rose(go_in_progress_o));
    c_load: cover property (|ratio_load_o);
    c_tick: cover property (fourth_system_clock_o && en_q);
endmodule

bind cdgs_top cdgs_props #(.PRIMARY(PRIMARY), .OSC_CYCLES(OSC_CYCLES)) u_cdgs_props (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ratio_write_i(ratio_write_i), .clk_on_i(clk_on_i),
    .fourth_system_clock_o(fourth_system_clock_o),
    .ratio_load_o(ratio_load_o), .align_restart_o(align_restart_o),
    .go_in_progress_o(go_in_progress_o), .irq_o(irq_o));

// ---- sim/cdgs_top_tb.sv ----
// testbench of the clock divider / go / status block
// assumes the register port of the top; primary and secondary instance
`timescale 1ns/1ns
module cdgs_top_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [5:0] ratio_write_i = 6'h00;
    logic [5:0] clk_on_i = 6'h3f; // all external clocks running
    logic [31:0] rdata_a, rdata_b, got_a, got_b;
    logic tick, go, irq;
    logic [5:0] load_o, align_o, load_seen, align_seen;
    logic [5:0] align_last; // last non-zero realign pulse
    int err_count = 0;
    int n_tests = 0;
    int n, i, r;

    cdgs_top #(.PRIMARY(1'b1), .OSC_CYCLES(0)) u_cdgs_top (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_a),
        .ratio_write_i(ratio_write_i), .clk_on_i(clk_on_i),
        .fourth_system_clock_o(tick), .ratio_load_o(load_o),
        .align_restart_o(align_o), .go_in_progress_o(go), .irq_o(irq));
    // secondary instance shares the bus, only read data observed
    // secondary also counts oscillator settling, to raise its event
    cdgs_top #(.PRIMARY(1'b0), .OSC_CYCLES(5)) u_cdgs_top_sec (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_b),
        .ratio_write_i(ratio_write_i), .clk_on_i(clk_on_i),
        .fourth_system_clock_o(), .ratio_load_o(), .align_restart_o(),
        .go_in_progress_o(), .irq_o());

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    // collects every load and realign pulse seen
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            load_seen <= 6'h00;
            align_seen <= 6'h00;
            align_last <= 6'h00;
        end else begin
            load_seen <= load_seen | load_o;
            align_seen <= align_seen | align_o;
            if (|align_o) align_last <= align_o;
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    // read data of both instances land in got_a and got_b
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        got_a = rdata_a;
        got_b = rdata_b;
    endtask
    task automatic wait_idle;
        i = 0;
        while (go !== 1'b0 && i < 20) begin
            @(posedge core_clk_i);
            #1;
            i++;
        end
        chk({31'h0, go}, 32'h0);
    endtask
    // cycles between two ticks of the fourth clock
    task automatic tick_gap(output int g);
        g = 0;
        i = 0;
        @(posedge core_clk_i);
        #1;
        while (tick !== 1'b1 && i < 20) begin
            @(posedge core_clk_i);
            #1;
            i++;
        end
        do begin
            @(posedge core_clk_i);
            #1;
            g++;
        end while (tick !== 1'b1 && g < 20);
    endtask
    task automatic summarize;
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        rd(cdgs_pkg::ADR_DIV4);
        chk(got_a, 32'h8003);
        chk(got_b, 32'h0);
        rd(cdgs_pkg::ADR_CMD);
        chk(got_a, 32'h0);
        rd(cdgs_pkg::ADR_STAT);
        chk(got_a, 32'h4);
        rd(cdgs_pkg::ADR_RUN);
        chk(got_a, 32'h3f);
        rd(8'h40);
        chk(got_a, 32'h0);
        tick_gap(n);
        chk(32'(n), 32'h4);
        // other divider rewritten, then own ratio changed without go
        @(posedge core_clk_i);
        ratio_write_i <= 6'h01;
        @(posedge core_clk_i);
        ratio_write_i <= 6'h00;
        rd(cdgs_pkg::ADR_CHG);
        chk(got_a, 32'h1);
        wr(cdgs_pkg::ADR_DIV4, 32'h8000);
        tick_gap(n);
        chk(32'(n), 32'h4);
        rd(cdgs_pkg::ADR_CHG);
        chk(got_a, 32'h9);
        // every ratio, loaded by go
        for (r = 0; r < 8; r++) begin
            wr(cdgs_pkg::ADR_DIV4, 32'h8000 | 32'(r));
            wr(cdgs_pkg::ADR_CMD, 32'h1);
            #1;
            chk({31'h0, go}, 32'h1);
            wait_idle();
            tick_gap(n);
            chk(32'(n), 32'(r + 1));
        end
        chk({26'h0, load_seen}, 32'h9);
        chk({26'h0, align_seen}, 32'h3f);
        rd(cdgs_pkg::ADR_CHG);
        chk(got_a, 32'h0);
        wr(cdgs_pkg::ADR_CMD, 32'h0);
        #1;
        chk({31'h0, go}, 32'h0);
        rd(cdgs_pkg::ADR_CMD);
        chk(got_a, 32'h0);
        // go done event: masked, unmasked, cleared
        chk({31'h0, irq}, 32'h0);
        rd(cdgs_pkg::ADR_IST);
        chk(got_a, 32'h1);
        chk(got_b, 32'h3);
        wr(cdgs_pkg::ADR_IMSK, 32'h1);
        @(posedge core_clk_i);
        #1;
        chk({31'h0, irq}, 32'h1);
        wr(cdgs_pkg::ADR_IST, 32'h1);
        @(posedge core_clk_i);
        #1;
        chk({31'h0, irq}, 32'h0);
        // only the selected clocks are realigned by go
        wr(cdgs_pkg::ADR_ALN, 32'h25);
        rd(cdgs_pkg::ADR_ALN);
        chk(got_a, 32'h25);
        wr(cdgs_pkg::ADR_CMD, 32'h1);
        #1;
        chk({31'h0, go}, 32'h1);
        wait_idle();
        chk({26'h0, align_last}, 32'h25);
        // divider disabled, some clocks gated
        clk_on_i <= 6'h15;
        wr(cdgs_pkg::ADR_DIV4, 32'h0);
        repeat (2) @(posedge core_clk_i);
        n = 0;
        repeat (12) begin
            @(posedge core_clk_i);
            #1;
            if (tick === 1'b1) n++;
        end
        chk(32'(n), 32'h0);
        rd(cdgs_pkg::ADR_RUN);
        chk(got_a, 32'h15);
        summarize();
    end
    // watchdog against a hang
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule
